// file: design/flash_bus_cycle.sv
// One asynchronous flash bus cycle: a write strobe pulse or a read with sampling.
`default_nettype none
module flash_bus_cycle
	import flash_seq_pkg::*;
(
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Request.
	input wire logic start_in,
	input wire logic is_read_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] data_in,
	output logic done_out,
	output logic [DATA_W-1:0] rdata_out,
	// Flash pins.
	output logic [ADDR_W-1:0] flash_addr_out,
	output logic [DATA_W-1:0] flash_dq_out,
	output logic flash_dq_oe_out,
	input wire logic [DATA_W-1:0] flash_dq_in,
	output logic flash_ce_n_out,
	output logic flash_we_n_out,
	output logic flash_oe_n_out
);
	localparam int TOTAL_W = WE_SETUP_CYC + WE_LOW_CYC + WE_HOLD_CYC;
	logic [5:0] cnt;
	logic busy;
	logic rd;
	logic [DATA_W-1:0] dq_s1;
	logic [DATA_W-1:0] dq_s2;
	wire [5:0] last = rd ? 6'(RD_CYC) : 6'(TOTAL_W);
	wire in_low = (cnt >= 6'(WE_SETUP_CYC)) && (cnt < 6'(WE_SETUP_CYC + WE_LOW_CYC));
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dq_s1 <= '0;
			dq_s2 <= '0;
		end else begin
			dq_s1 <= flash_dq_in;
			dq_s2 <= dq_s1;
		end
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt <= '0;
			busy <= 1'b0;
			rd <= 1'b0;
			done_out <= 1'b0;
			rdata_out <= '0;
			flash_addr_out <= '0;
			flash_dq_out <= '0;
			flash_dq_oe_out <= 1'b0;
			flash_ce_n_out <= 1'b1;
			flash_we_n_out <= 1'b1;
			flash_oe_n_out <= 1'b1;
		end else begin
			done_out <= 1'b0;
			if (!busy && start_in) begin
				busy <= 1'b1;
				rd <= is_read_in;
				cnt <= '0;
				flash_addr_out <= addr_in;
				flash_dq_out <= data_in;
				flash_dq_oe_out <= !is_read_in;
				flash_ce_n_out <= 1'b0;
				flash_oe_n_out <= !is_read_in;
			end else if (busy) begin
				cnt <= cnt + 6'd1;
				// Data is latched by the device at the strobe's rising edge.
				flash_we_n_out <= rd || !in_low;
				if (cnt == last) begin
					busy <= 1'b0;
					done_out <= 1'b1;
					flash_ce_n_out <= 1'b1;
					flash_oe_n_out <= 1'b1;
					flash_we_n_out <= 1'b1;
					flash_dq_oe_out <= 1'b0;
					if (rd) begin
						rdata_out <= dq_s2;
					end
				end
			end
		end
	end
endmodule // flash_bus_cycle
`default_nettype wire

// file: design/flash_seq_host.sv
// Host controller that issues program, erase, suspend and resume sequences to a parallel NOR flash.
`default_nettype none
module flash_seq_host
	import flash_seq_pkg::*;
#(
	parameter int SECTOR_GAP = SECTOR_GAP_CYC,
	parameter int SUSPEND_WAIT = SUSPEND_CYC
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Register port.
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// Flash pins.
	output logic [ADDR_W-1:0] flash_addr_out,
	output logic [DATA_W-1:0] flash_dq_out,
	output logic flash_dq_oe_out,
	input wire logic [DATA_W-1:0] flash_dq_in,
	output logic flash_ce_n_out,
	output logic flash_we_n_out,
	output logic flash_oe_n_out,
	output logic flash_byte_n_out,
	output logic flash_reset_n_out,
	input wire logic ready_busy_pin_in
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ISSUE = 3'b001,
		ST_WAIT = 3'b010,
		ST_GAP = 3'b011,
		ST_POLL = 3'b100
	} state_t;
	state_t state;
	state_t next_state;
	logic [3:0] op;
	logic [2:0] step;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] data;
	logic [DATA_W-1:0] rdata;
	logic bypass;
	logic suspended;
	logic failed;
	logic [15:0] timer;
	logic rb_s1;
	logic rb_s2;
	logic cyc_start;
	logic cyc_done;
	logic [DATA_W-1:0] cyc_rdata;
	// Count of bus cycles each operation needs.
	function automatic logic [2:0] op_len(input logic [3:0] o);
		case (o)
			OP_PROGRAM: op_len = 3'd4;
			OP_BYP_ENTER: op_len = 3'd3;
			OP_BYP_PROGRAM: op_len = 3'd2;
			OP_BYP_EXIT: op_len = 3'd2;
			OP_CHIP_ERASE: op_len = 3'd6;
			OP_SECTOR_ERASE: op_len = 3'd6;
			default: op_len = 3'd1;
		endcase
	endfunction
	// Address and low data byte of each step; upper data byte is zero on command cycles.
	function automatic logic [ADDR_W+7:0] op_step(input logic [3:0] o, input logic [2:0] s,
			input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] sa;
		sa = {a[ADDR_W-1:SECTOR_LSB], {SECTOR_LSB{1'b0}}};
		op_step = {UNLOCK1_ADDR, UNLOCK1_DATA};
		case (o)
			OP_PROGRAM, OP_BYP_ENTER, OP_CHIP_ERASE, OP_SECTOR_ERASE: begin
				case (s)
					3'd0, 3'd3: op_step = {UNLOCK1_ADDR, UNLOCK1_DATA};
					3'd1, 3'd4: op_step = {UNLOCK2_ADDR, UNLOCK2_DATA};
					3'd2: op_step = {UNLOCK1_ADDR, o == OP_PROGRAM ? CMD_PROGRAM :
						o == OP_BYP_ENTER ? CMD_BYPASS : CMD_ERASE_SETUP};
					3'd5: op_step = (o == OP_CHIP_ERASE) ? {UNLOCK1_ADDR, CMD_CHIP_ERASE} :
						{sa, CMD_SECTOR_ERASE};
					default: op_step = {UNLOCK1_ADDR, UNLOCK1_DATA};
				endcase
			end
			OP_BYP_PROGRAM: op_step = {UNLOCK1_ADDR, CMD_PROGRAM};
			OP_BYP_EXIT: op_step = {a, (s == 3'd0) ? CMD_BYPASS_EXIT1 : CMD_BYPASS_EXIT2};
			OP_SECTOR_ADD: op_step = {sa, CMD_SECTOR_ERASE};
			OP_SUSPEND: op_step = {UNLOCK1_ADDR, CMD_SUSPEND};
			OP_RESUME: op_step = {UNLOCK1_ADDR, CMD_RESUME};
			default: op_step = {a, 8'h00};
		endcase
	endfunction
	wire is_prog = (op == OP_PROGRAM) || (op == OP_BYP_PROGRAM);
	wire [2:0] len = is_prog ? 3'(op_len(op)) : op_len(op);
	wire data_step = is_prog && (step == len - 3'd1);
	wire [ADDR_W+7:0] cur = op_step(op, step, addr);
	wire [ADDR_W-1:0] cyc_addr = data_step ? addr : cur[ADDR_W+7:8];
	wire [DATA_W-1:0] cyc_data = data_step ? data : {8'h00, cur[7:0]};
	wire cyc_read = (op == OP_READ);
	wire busy_dev = !rb_s2;
	wire needs_poll = is_prog || (op == OP_CHIP_ERASE);
	wire last_step = (step == len - 3'd1);
	always_comb begin
		next_state = state;
		cyc_start = 1'b0;
		case (state)
			ST_IDLE: next_state = state;
			ST_ISSUE: begin
				cyc_start = 1'b1;
				next_state = ST_WAIT;
			end
			ST_WAIT: begin
				if (cyc_done) begin
					if (!last_step) begin
						next_state = ST_ISSUE;
					end else if (needs_poll) begin
						next_state = ST_POLL;
					end else if (op == OP_SECTOR_ERASE || op == OP_SECTOR_ADD || op == OP_SUSPEND) begin
						next_state = ST_GAP;
					end else begin
						next_state = ST_IDLE;
					end
				end
			end
			ST_GAP: next_state = (timer == 16'd0) ? ST_IDLE : ST_GAP;
			ST_POLL: next_state = (timer == 16'd0 && !busy_dev) ? ST_IDLE : ST_POLL;
			default: next_state = ST_IDLE;
		endcase
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rb_s1 <= 1'b1;
			rb_s2 <= 1'b1;
		end else begin
			rb_s1 <= ready_busy_pin_in;
			rb_s2 <= rb_s1;
		end
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= ST_IDLE;
			op <= OP_READ;
			step <= '0;
			addr <= '0;
			data <= '0;
			rdata <= '0;
			bypass <= 1'b0;
			suspended <= 1'b0;
			failed <= 1'b0;
			timer <= '0;
			flash_byte_n_out <= 1'b1;
			flash_reset_n_out <= 1'b1;
			reg_rdata_out <= '0;
		end else begin
			state <= next_state;
			flash_reset_n_out <= 1'b1;
			reg_rdata_out <= '0;
			if (reg_rd_in) begin
				case (reg_addr_in)
					REG_ADDR: reg_rdata_out <= 32'(addr);
					REG_DATA: reg_rdata_out <= 32'(data);
					// Bit 1 reads high while byte-wide transfers are selected.
					REG_STATUS: reg_rdata_out <= {26'h0, failed, busy_dev, suspended, bypass,
						!flash_byte_n_out, state != ST_IDLE};
					REG_RDATA: reg_rdata_out <= 32'(rdata);
					default: reg_rdata_out <= '0;
				endcase
			end
			if (reg_wr_in && state == ST_IDLE) begin
				case (reg_addr_in)
					REG_ADDR: addr <= reg_wdata_in[ADDR_W-1:0];
					REG_DATA: data <= reg_wdata_in[DATA_W-1:0];
					REG_CMD: begin
						// Bit 8 pulses hardware reset, which aborts any embedded operation.
						if (reg_wdata_in[8]) begin
							flash_reset_n_out <= 1'b0;
							bypass <= 1'b0;
							suspended <= 1'b0;
						end else if (cmd_ok_w(reg_wdata_in[3:0])) begin
							op <= reg_wdata_in[3:0];
							flash_byte_n_out <= !reg_wdata_in[4];
							step <= '0;
							failed <= 1'b0;
							state <= ST_ISSUE;
						end else begin
							failed <= 1'b1;
						end
					end
					default: failed <= failed;
				endcase
			end
			if (state == ST_WAIT && cyc_done) begin
				step <= step + 3'd1;
				if (cyc_read) begin
					rdata <= cyc_rdata;
				end
				if (last_step) begin
					timer <= needs_poll ? 16'd4 : (op == OP_SUSPEND) ? 16'(SUSPEND_WAIT) : 16'(SECTOR_GAP);
					if (op == OP_BYP_ENTER) bypass <= 1'b1;
					if (op == OP_BYP_EXIT) bypass <= 1'b0;
					if (op == OP_SUSPEND) suspended <= 1'b1;
					if (op == OP_RESUME) suspended <= 1'b0;
				end
			end else if (timer != 16'd0) begin
				timer <= timer - 16'd1;
			end
		end
	end
	// Command legality against host-tracked mode, evaluated on a candidate operation code.
	function automatic logic cmd_ok_w(input logic [3:0] o);
		case (o)
			OP_BYP_PROGRAM, OP_BYP_EXIT: cmd_ok_w = bypass;
			OP_RESUME: cmd_ok_w = suspended;
			OP_SUSPEND, OP_SECTOR_ADD, OP_READ: cmd_ok_w = 1'b1;
			OP_PROGRAM, OP_BYP_ENTER, OP_CHIP_ERASE, OP_SECTOR_ERASE: cmd_ok_w = !bypass && !suspended;
			default: cmd_ok_w = 1'b0;
		endcase
	endfunction
	flash_bus_cycle u_cycle (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.start_in(cyc_start),
		.is_read_in(cyc_read),
		.addr_in(cyc_addr),
		.data_in(cyc_data),
		.done_out(cyc_done),
		.rdata_out(cyc_rdata),
		.flash_addr_out(flash_addr_out),
		.flash_dq_out(flash_dq_out),
		.flash_dq_oe_out(flash_dq_oe_out),
		.flash_dq_in(flash_dq_in),
		.flash_ce_n_out(flash_ce_n_out),
		.flash_we_n_out(flash_we_n_out),
		.flash_oe_n_out(flash_oe_n_out)
	);
	chk_one_strobe: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!(flash_we_n_out == 1'b0 && flash_oe_n_out == 1'b0)) else $error("write and read strobes overlap");
	chk_issue_starts: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		state == ST_ISSUE |=> !flash_ce_n_out) else $error("issue did not start a cycle");
	chk_bypass_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(state == ST_WAIT && cyc_done && last_step && op == OP_BYP_ENTER) |=> bypass) else $error("bypass not entered");
	chk_bypass_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(state == ST_WAIT && cyc_done && last_step && op == OP_BYP_EXIT) |=> !bypass) else $error("bypass not left");
	chk_poll_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(state == ST_POLL && busy_dev) |=> state == ST_POLL) else $error("left poll while busy");
	chk_upper_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(cyc_start && !data_step && !cyc_read) |=> flash_dq_out[15:8] == 8'h00) else $error("upper byte set");
	chk_sector_bits: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(cyc_start && (op == OP_SECTOR_ADD || (op == OP_SECTOR_ERASE && last_step)))
		|=> flash_addr_out[SECTOR_LSB-1:0] == '0) else $error("sector low bits set");
	chk_resume_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(state == ST_WAIT && cyc_done && op == OP_RESUME) |=> !suspended) else $error("resume kept suspend");
endmodule // flash_seq_host
`default_nettype wire

// file: design/flash_seq_pkg.sv
// Package with command codes, addresses and timing constants for the flash command sequencer.
// Summary of operation
// - Program: two unlocks, A0h, then address/data.
// - Hardware reset aborts program; host reissues. Not done here: bit 8 only pulses reset and clears bypass and suspend.
// - Bypass entry: two unlocks, then 20h.
// - Bypass program: A0h then address/data pair.
// - Bypass exit: 90h then 00h.
// - Chip erase: six writes ending 10h.
// - Sector erase: six writes, last sector 30h.
// - Host spaces extra sector writes under 50 us.
`default_nettype none
package flash_seq_pkg;
	localparam int ADDR_W = 18;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 18'h00555;
	localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 18'h002aa;
	localparam logic [7:0] UNLOCK1_DATA = 8'haa;
	localparam logic [7:0] UNLOCK2_DATA = 8'h55;
	localparam logic [7:0] CMD_PROGRAM = 8'ha0;
	localparam logic [7:0] CMD_BYPASS = 8'h20;
	localparam logic [7:0] CMD_BYPASS_EXIT1 = 8'h90;
	localparam logic [7:0] CMD_BYPASS_EXIT2 = 8'h00;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
	localparam logic [7:0] CMD_SUSPEND = 8'hb0;
	localparam logic [7:0] CMD_RESUME = 8'h30;
	localparam int SECTOR_LSB = 12;
	localparam int CLK_MHZ = 200;
	localparam int WINDOW_US = 50;
	localparam int WINDOW_MARGIN_US = 10;
	// Extra sector writes are spaced well inside the window.
	localparam int SECTOR_GAP_CYC = (WINDOW_US - WINDOW_MARGIN_US) * CLK_MHZ;
	localparam int SUSPEND_US = 20;
	localparam int SUSPEND_CYC = SUSPEND_US * CLK_MHZ;
	// Bus strobe phases in clock cycles: setup, low pulse, recovery.
	localparam int WE_SETUP_CYC = 2;
	localparam int WE_LOW_CYC = 8;
	localparam int WE_HOLD_CYC = 4;
	localparam int RD_CYC = 16;
	localparam logic [3:0] OP_PROGRAM = 4'h1;
	localparam logic [3:0] OP_BYP_ENTER = 4'h2;
	localparam logic [3:0] OP_BYP_PROGRAM = 4'h3;
	localparam logic [3:0] OP_BYP_EXIT = 4'h4;
	localparam logic [3:0] OP_CHIP_ERASE = 4'h5;
	localparam logic [3:0] OP_SECTOR_ERASE = 4'h6;
	localparam logic [3:0] OP_SECTOR_ADD = 4'h7;
	localparam logic [3:0] OP_SUSPEND = 4'h8;
	localparam logic [3:0] OP_RESUME = 4'h9;
	localparam logic [3:0] OP_READ = 4'ha;
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_DATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_RDATA = 8'h10;
endpackage
`default_nettype wire

// file: test/flash_dev_model.sv
// Behavioural parallel NOR flash that decodes command cycles, logs every write and drives status.
`default_nettype none
module flash_dev_model
	import flash_seq_pkg::*;
#(
	parameter int WIN_CYC = WINDOW_US * CLK_MHZ
) (
	// Clock and hardware reset.
	input wire logic clk_in,
	input wire logic reset_n_in,
	// Bus.
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] dq_in,
	input wire logic ce_n_in,
	input wire logic we_n_in,
	input wire logic oe_n_in,
	output logic [DATA_W-1:0] dq_out,
	output logic ready_busy_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [ADDR_W-1:0] log_a [0:63];
	logic [DATA_W-1:0] log_d [0:63];
	logic [DATA_W-1:0] mem [0:63];
	logic [DATA_W-1:0] last = 16'h0;
	logic [5:0] esec = 6'h0;
	logic we_q = 1'b1;
	logic byp = 0, pnext = 0, exit1 = 0, win = 0, ers = 0, susp = 0;
	int n_wr = 0, n_sec = 0, n_rst = 0, step = 0, busy = 0, wcnt = 0;
	wire logic rd_en = !ce_n_in && !oe_n_in;
	wire logic wr_end = !ce_n_in && we_n_in && !we_q;
	wire logic [7:0] c = dq_in[7:0];
	wire logic [10:0] u = addr_in[10:0];
	initial for (int i = 0; i < 64; i++) mem[i] = 16'hffff;
	// A released bus shows the inverse of the last value, so a stale sample cannot pass.
	assign dq_out = !rd_en ? ~last : (susp && addr_in[17:12] == esec) ? 16'h0080 : mem[addr_in[5:0]];
	assign ready_busy_out = susp || (busy == 0 && !win);
	always @(negedge reset_n_in) n_rst <= n_rst + 1;
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			{byp, pnext, exit1, win, ers, susp} <= 6'h0;
			busy <= 0;
			step <= 0;
		end else begin
			we_q <= we_n_in;
			if (rd_en) last <= dq_out;
			if (busy != 0 && !susp) busy <= busy - 1;
			if (busy == 1 && !susp) ers <= 1'b0;
			if (wcnt != 0) wcnt <= wcnt - 1;
			if (win && wcnt == 1) begin
				win <= 1'b0;
				ers <= 1'b1;
				busy <= 200;
			end
			if (wr_end) begin
				log_a[n_wr[5:0]] <= addr_in;
				log_d[n_wr[5:0]] <= dq_in;
				n_wr <= n_wr + 1;
				if (susp) begin
					// Any other write leaves the suspended state standing.
					if (c == CMD_RESUME) susp <= 1'b0;
				end else if ((busy != 0 && !ers) || (ers && c != CMD_SUSPEND)) begin
					step <= 0;
				end else if (ers || (win && c == CMD_SUSPEND)) begin
					susp <= 1'b1;
					win <= 1'b0;
					ers <= 1'b1;
					if (win) busy <= 200;
				end else if (pnext) begin
					mem[addr_in[5:0]] <= mem[addr_in[5:0]] & dq_in;
					pnext <= 1'b0;
					busy <= 20;
				end else if (byp) begin
					pnext <= c == CMD_PROGRAM;
					exit1 <= c == CMD_BYPASS_EXIT1;
					if (exit1 && c == CMD_BYPASS_EXIT2) byp <= 1'b0;
				end else if (win && c == CMD_SECTOR_ERASE) begin
					n_sec <= n_sec + 1;
					wcnt <= WIN_CYC;
					esec <= addr_in[17:12];
				end else if (win) begin
					win <= 1'b0;
				end else if (step == 0 || step == 3) begin
					step <= (u == UNLOCK1_ADDR[10:0] && c == UNLOCK1_DATA) ? step + 1 : 0;
				end else if (step == 1 || step == 4) begin
					step <= (u == UNLOCK2_ADDR[10:0] && c == UNLOCK2_DATA) ? step + 1 : 0;
				end else begin
					step <= (step == 2 && c == CMD_ERASE_SETUP) ? 3 : 0;
					pnext <= step == 2 && c == CMD_PROGRAM;
					byp <= step == 2 && c == CMD_BYPASS;
					if (step == 5 && c == CMD_CHIP_ERASE) busy <= 400;
					if (step == 5 && c == CMD_SECTOR_ERASE) begin
						win <= 1'b1;
						wcnt <= WIN_CYC;
						n_sec <= n_sec + 1;
						esec <= addr_in[17:12];
					end
				end
			end
		end
	end
endmodule // flash_dev_model
`default_nettype wire

// file: test/flash_seq_host_tb.sv
// Self-checking bench for the flash sequencer host against a behavioural flash.
`default_nettype none
module flash_seq_host_tb
	import flash_seq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [17:0] U = 18'h007ff;
	localparam logic [17:0] S = 18'h3f000;
	localparam logic [15:0] C = 16'h00ff;
	logic clk_in = 0, rst_n_in = 0, reg_wr_in = 0, reg_rd_in = 0;
	logic [7:0] reg_addr_in = 8'h0;
	logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, s;
	logic [ADDR_W-1:0] fa;
	logic [DATA_W-1:0] fdo, mdo, bus;
	logic foe, ce_n, we_n, oe_n, byte_n, frst_n, rdy;
	int mismatches = 0, n_checks = 0, wi = 0, k;
	assign bus = foe ? fdo : mdo;
	always #2.5 clk_in = ~clk_in;
	flash_seq_host #(.SECTOR_GAP(8), .SUSPEND_WAIT(8)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .flash_addr_out(fa), .flash_dq_out(fdo), .flash_dq_oe_out(foe),
		.flash_dq_in(bus), .flash_ce_n_out(ce_n), .flash_we_n_out(we_n), .flash_oe_n_out(oe_n),
		.flash_byte_n_out(byte_n), .flash_reset_n_out(frst_n), .ready_busy_pin_in(rdy));
	flash_dev_model m (.clk_in(clk_in), .reset_n_in(frst_n), .addr_in(fa), .dq_in(bus), .ce_n_in(ce_n),
		.we_n_in(we_n), .oe_n_in(oe_n), .dq_out(mdo), .ready_busy_out(rdy));
	task automatic complete_run();
		if (mismatches == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1;
		d = reg_rdata_out;
		@(posedge clk_in);
	endtask
	task automatic go(input logic [31:0] cmd);
		int n;
		wr(REG_CMD, cmd);
		s = 32'h1;
		for (n = 0; n < 3000 && s[0] !== 1'b0; n++)
			rd(REG_STATUS, s);
		if (s[0] !== 1'b0) begin
			mismatches++;
			$display("ERROR %0t sequencer stuck busy", $time);
		end
	endtask
	task automatic ew(input logic [17:0] a, input logic [15:0] d, input logic [17:0] am, input logic [15:0] dm);
		chk({14'h0, m.log_a[wi] & am}, {14'h0, a & am});
		chk({16'h0, m.log_d[wi] & dm}, {16'h0, d & dm});
		wi++;
	endtask
	task automatic ul();
		ew(UNLOCK1_ADDR, {8'h0, UNLOCK1_DATA}, U, C);
		ew(UNLOCK2_ADDR, {8'h0, UNLOCK2_DATA}, U, C);
	endtask
	task automatic st(input logic [31:0] mask, input logic [31:0] exp);
		rd(REG_STATUS, s);
		chk(s & mask, exp);
	endtask
	initial begin
		#100000;
		mismatches++;
		complete_run();
	end
	initial begin
		repeat (6) @(posedge clk_in);
		rst_n_in <= 1'b1;
		@(posedge clk_in);
		st(32'hffffffff, 32'h0);
		chk({31'h0, byte_n}, 32'h1);
		wr(REG_ADDR, 32'h00123);
		wr(REG_DATA, 32'h0000f0f5);
		// The second command lands while busy and must leave no trace on the bus.
		wr(REG_CMD, {28'h0, OP_PROGRAM});
		go({28'h0, OP_CHIP_ERASE});
		ul();
		ew(UNLOCK1_ADDR, 16'h00a0, U, C);
		ew(18'h00123, 16'hf0f5, 18'h3ffff, 16'hffff);
		wr(REG_DATA, 32'h00000ff0);
		go({28'h0, OP_PROGRAM});
		wi += 4;
		chk(32'(m.n_wr), 32'(wi));
		go({28'h0, OP_READ});
		rd(REG_RDATA, s);
		chk(s & 32'hffff, 32'h00f0);
		go({28'h0, OP_BYP_ENTER});
		ul();
		ew(UNLOCK1_ADDR, 16'h0020, U, C);
		st(32'h4, 32'h4);
		wr(REG_ADDR, 32'h00140);
		wr(REG_DATA, 32'h00001234);
		for (k = 0; k < 2; k++) begin
			go({28'h0, OP_BYP_PROGRAM});
			ew(18'h0, 16'h00a0, 18'h0, C);
			ew(18'h00140, 16'h1234, 18'h3ffff, 16'hffff);
		end
		go({28'h0, OP_BYP_EXIT});
		ew(18'h0, 16'h0090, 18'h0, C);
		ew(18'h0, 16'h0000, 18'h0, C);
		st(32'h4, 32'h0);
		go({28'h0, OP_BYP_PROGRAM});
		st(32'h20, 32'h20);
		chk(32'(m.n_wr), 32'(wi));
		go({28'h0, OP_CHIP_ERASE});
		for (k = 0; k < 2; k++) begin
			ul();
			ew(UNLOCK1_ADDR, k ? 16'h0010 : 16'h0080, U, C);
		end
		wr(REG_ADDR, 32'h3f000);
		go({28'h0, OP_SECTOR_ERASE});
		ul();
		ew(UNLOCK1_ADDR, 16'h0080, U, C);
		ul();
		ew(18'h3f000, 16'h0030, S, C);
		// Low address bits are set here so that only the sector bits can be matched.
		wr(REG_ADDR, 32'h05123);
		go({28'h0, OP_SECTOR_ADD});
		ew(18'h05000, 16'h0030, S, C);
		chk(32'(m.n_sec), 32'h2);
		go({28'h0, OP_SUSPEND});
		ew(18'h0, 16'h00b0, 18'h0, C);
		st(32'h8, 32'h8);
		wr(REG_ADDR, 32'h05001);
		go({28'h0, OP_READ});
		rd(REG_RDATA, s);
		chk(s & 32'hffff, 32'h0080);
		go({28'h0, OP_RESUME});
		ew(18'h0, 16'h0030, 18'h0, C);
		st(32'h8, 32'h0);
		go(32'h00000100);
		chk(32'(m.n_rst), 32'h1);
		go({27'h0, 1'b1, OP_READ});
		st(32'h2, 32'h2);
		chk({31'h0, byte_n}, 32'h0);
		rd(REG_ADDR, s);
		chk(s, 32'h00005001);
		rd(REG_DATA, s);
		chk(s, 32'h00001234);
		complete_run();
	end
endmodule // flash_seq_host_tb
`default_nettype wire
